/* logic/rtc_pkg.sv */
// Shared constants for the clock control and trim block.
package rtc_pkg;

  // ------------------------------------------------------------
  // Register bus shape and register indices
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 16;
  localparam int          IDX_W        = 6;
  localparam logic [IDX_W-1:0] IDX_TRIM     = 6'h18;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h19;
  localparam logic [IDX_W-1:0] IDX_SUBSEC   = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_SEC_HI   = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_SEC_LO   = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int B_RUN     = 0;
  localparam int B_TOD     = 1;
  localparam int B_SUB     = 2;
  localparam int B_BUSY    = 3;
  localparam int B_RDY     = 4;
  localparam int B_READY_IRQ_ENABLE    = 5;
  localparam int B_OSCRDY  = 13;
  localparam int B_WE      = 15;
  localparam logic [DATA_W-1:0] CTRL_RETAIN_MASK = 16'h5c01;
  localparam logic [DATA_W-1:0] CTRL_PLAIN_MASK  = 16'h0326;
  localparam logic [DATA_W-1:0] CTRL_RESET       = 16'h0000;

  // ------------------------------------------------------------
  // Trim register fields and timing
  // ------------------------------------------------------------
  localparam int TRIM_W        = 7;
  localparam int B_DIR         = 7;
  localparam int OSC_HZ        = 32768;
  localparam int TICK_HZ       = 256;
  localparam int PRE_W         = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_HZ / TICK_HZ - 1);
  localparam int TRIM_PERIOD_S = 10;
  localparam int PERIOD_W      = 19;
  localparam int TRIM_PERIOD_EDGES = TRIM_PERIOD_S * OSC_HZ;
  localparam logic [1:0] BUSY_EDGES = 2'h2;
  localparam int SUB_W         = 8;
  localparam int SEC_W         = 32;

  // ------------------------------------------------------------
  // Interrupt status layout
  // ------------------------------------------------------------
  localparam int IRQ_W   = 3;
  localparam int IRQ_RDY = 0;
  localparam int IRQ_TOD = 1;
  localparam int IRQ_SUB = 2;

endpackage : rtc_pkg

/* logic/rtc_tick_if.sv */
// Bundle between the control block and the 256 Hz tick generator.
`timescale 1ns/1ps
`default_nettype none
interface rtc_tick_if;
  import rtc_pkg::*;
  logic              edge32;
  logic              run;
  logic [TRIM_W-1:0] trim_count;
  logic              trim_direction;
  logic              tick;
  modport gen  (input edge32, run, trim_count, trim_direction, output tick);
  modport ctrl (output edge32, run, trim_count, trim_direction, input tick);
endinterface : rtc_tick_if
`default_nettype wire

/* logic/rtc_pin_sync.sv */
// Three-stage pin synchroniser with a settled level and a rise pulse.
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Pin and result
  input  wire logic pin,
  output var  logic level,
  output var  logic rise
);
  logic s1, s2, s3;

  // A change is taken only once stages two and three agree, filtering one-cycle glitches.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= (s2 == s3) ? s3 : level;
      rise  <= (s2 == s3) && s3 && !level;
    end
  end
endmodule : rtc_pin_sync
`default_nettype wire

/* logic/rtc_tick_gen.sv */
// Divides the 32K edges to 256 Hz ticks and applies the ten-second trim.
`timescale 1ns/1ps
`default_nettype none
module rtc_tick_gen #(
  parameter int PERIOD_EDGES = rtc_pkg::TRIM_PERIOD_EDGES
) (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   resetn,
  // Link to the control block
  rtc_tick_if.gen     tk
);
  import rtc_pkg::*;

  localparam logic [PERIOD_W-1:0] PERIOD_LAST = PERIOD_W'(PERIOD_EDGES - 1);

  logic [PRE_W-1:0]    pre;
  logic [PERIOD_W-1:0] period;
  logic [TRIM_W-1:0]   pend;
  logic                dir;

  // ------------------------------------------------------------
  // Step decode
  // ------------------------------------------------------------
  // Removal swallows real edges; insertion adds steps between edges, so the
  // insert rate is bounded by mclk and never collides with a real edge.
  wire step_in   = tk.run && tk.edge32;
  wire pending   = (pend != '0);
  wire swallow   = step_in && pending && dir;                    // [R13]
  wire extra     = tk.run && !tk.edge32 && pending && !dir;      // [R13]
  wire advance   = (step_in && !swallow) || extra;               // [R1]
  wire wrap      = advance && (pre == PRE_LAST);                 // [R16]
  wire period_end = step_in && (period == PERIOD_LAST);

  // Prescaler and tick output.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre     <= '0;
      tk.tick <= 1'b0;
    end else begin
      pre     <= advance ? pre + 1'b1 : pre;
      tk.tick <= wrap;
    end
  end

  // Ten-second window; the trim amount is latched at its end.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      period <= '0;
      pend   <= '0;
      dir    <= 1'b0;
    end else begin
      period <= period_end ? '0 : (step_in ? period + 1'b1 : period);
      if (period_end) begin
        pend <= tk.trim_count;                                    // [R12]
        dir  <= tk.trim_direction;
      end else if (swallow || extra) begin
        pend <= pend - 1'b1;
      end
    end
  end
endmodule : rtc_tick_gen
`default_nettype wire

/* logic/rtc_ctrl_trim.sv */
// Control, status, counters and trim of the real-time clock, with its register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] Run enable gates divided clock to counters.
// [R2] Time-of-day alarm interrupts only when enabled.
// [R3] Subsecond alarm interrupts only when enabled.
// [R4] Busy sets on reset, writes, enable changes.
// [R5] Software waits for busy clear after writes.
// [R6] Ready sets on count update, clears before.
// [R7] Ready cleared by zero only while running.
// [R8] Ready interrupt only with ready enable set.
// [R9] Run enable writable only with write-enable, not busy.
// [R10] Busy, osc ready read-only; write-enable always writable.
// [R11] Retained control bits survive all but power-on.
// [R12] Every ten seconds adjust by trim count.
// [R13] Direction bit chooses insert or remove.
// [R14] Trim writable only with write-enable, not busy.
// [R15] Write-enable bit guards run enable and trim.
// [R16] Subsecond counts 256 Hz, rollover drives seconds.
// [R17] Writes cross into 32K domain; busy until seen.
module rtc_ctrl_trim #(
  parameter int TRIM_PERIOD_EDGES = rtc_pkg::TRIM_PERIOD_EDGES
) (
  // Clock and resets
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        por_n,
  // Register port
  input  wire logic [rtc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [rtc_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output var  logic [rtc_pkg::DATA_W-1:0]  rdata,
  // Oscillator pins
  input  wire logic                        osc_clk32,
  input  wire logic                        osc_ready,
  // Alarm events from the comparators
  input  wire logic                        tod_alarm_hit,
  input  wire logic                        subsec_alarm_hit,
  // Interrupt
  output var  logic                        irq
);
  import rtc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_plain;     // Non-retained writable bits.
  logic [DATA_W-1:0] ctrl_keep;      // Bits held through every reset but power-on.
  logic              write_enable;
  logic              busy;
  logic [1:0]        busy_cnt;
  logic              ready;
  logic [TRIM_W:0]   clock_trim;
  logic [SUB_W-1:0]  subsec;
  logic [SEC_W-1:0]  seconds;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic              run_copy;
  logic [TRIM_W:0]   trim_copy;
  logic              tick_d;
  logic              osc_ready_flag;
  logic              edge32;

  rtc_tick_if tk ();

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  rtc_pin_sync u_clk_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin    (osc_clk32),
    .level  (),
    .rise   (edge32)
  );

  rtc_pin_sync u_rdy_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin    (osc_ready),
    .level  (osc_ready_flag),
    .rise   ()
  );

  // ------------------------------------------------------------
  // Tick generator
  // ------------------------------------------------------------
  assign tk.edge32         = edge32;
  assign tk.run            = run_copy;
  assign tk.trim_count     = trim_copy[TRIM_W-1:0];
  assign tk.trim_direction = trim_copy[B_DIR];

  rtc_tick_gen #(
    .PERIOD_EDGES (TRIM_PERIOD_EDGES)
  ) u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tk     (tk)
  );

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire [IDX_W-1:0] idx     = addr[ADDR_W-1:2];
  wire             aligned = (addr[1:0] == 2'h0);
  wire hit_trim  = aligned && (idx == IDX_TRIM);
  wire hit_ctrl  = aligned && (idx == IDX_CTRL);
  wire hit_sub   = aligned && (idx == IDX_SUBSEC);
  wire hit_sechi = aligned && (idx == IDX_SEC_HI);
  wire hit_seclo = aligned && (idx == IDX_SEC_LO);
  wire hit_stat  = aligned && (idx == IDX_IRQ_STAT);
  wire hit_mask  = aligned && (idx == IDX_IRQ_MASK);

  // ------------------------------------------------------------
  // Write qualification
  // ------------------------------------------------------------
  // The write-enable bit guards only the run bit and trim; other control bits
  // need only an idle busy flag, but write-enable and the ready clear need none.
  wire run_now    = ctrl_keep[B_RUN];
  wire wr_ctrl    = wr && hit_ctrl;
  wire ctrl_open  = wr_ctrl && !busy;                                   // [R10]
  wire run_open   = ctrl_open && write_enable;                          // [R9] [R15]
  wire trim_open  = wr && hit_trim && write_enable && !busy;            // [R14] [R15]
  wire count_open = wr && !busy && !run_now && (hit_sub || hit_sechi || hit_seclo);
  wire en_change  = (ctrl_open && (wdata[B_SUB:B_TOD] != ctrl_plain[B_SUB:B_TOD]))
                 || (run_open && (wdata[B_RUN] != run_now));
  wire busy_start = en_change || trim_open || count_open;               // [R4]

  // Keep-mask for the retained bits; the run bit follows its stricter gate.
  wire [DATA_W-1:0] keep_wmask = ctrl_open
                               ? (CTRL_RETAIN_MASK & ~(DATA_W'(1) << B_RUN)) : '0;
  wire [DATA_W-1:0] next_keep  = (ctrl_keep & ~keep_wmask) | (wdata & keep_wmask);

  // ------------------------------------------------------------
  // Ready and interrupt events
  // ------------------------------------------------------------
  wire tick       = tk.tick;
  wire rdy_sw_clr = wr_ctrl && !wdata[B_RDY] && run_now;                // [R7]
  wire rdy_set    = tick_d;                                             // [R6]
  wire next_ready = rdy_set ? 1'b1 : ((tick || rdy_sw_clr) ? 1'b0 : ready);  // [R6]

  wire [IRQ_W-1:0] irq_set;
  assign irq_set[IRQ_RDY] = rdy_set && !ready && ctrl_plain[B_READY_IRQ_ENABLE];    // [R8]
  assign irq_set[IRQ_TOD] = tod_alarm_hit && ctrl_plain[B_TOD];         // [R2]
  assign irq_set[IRQ_SUB] = subsec_alarm_hit && ctrl_plain[B_SUB];      // [R3]
  wire [IRQ_W-1:0] irq_clr      = (rd && hit_stat) ? '1 : '0;
  wire [IRQ_W-1:0] next_stat    = (irq_stat & ~irq_clr) | irq_set;
  wire             next_irq     = |(next_stat & irq_mask);

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  wire [DATA_W-1:0] ctrl_view = ctrl_plain | ctrl_keep
                              | (DATA_W'(write_enable)   << B_WE)
                              | (DATA_W'(osc_ready_flag) << B_OSCRDY)
                              | (DATA_W'(ready)          << B_RDY)
                              | (DATA_W'(busy)           << B_BUSY);
  wire [DATA_W-1:0] next_rdata =
      !rd       ? '0 :
      hit_trim  ? DATA_W'(clock_trim) :
      hit_ctrl  ? ctrl_view :
      hit_sub   ? DATA_W'(subsec) :
      hit_sechi ? seconds[SEC_W-1:DATA_W] :
      hit_seclo ? seconds[DATA_W-1:0] :
      hit_stat  ? DATA_W'(irq_stat) :
      hit_mask  ? DATA_W'(irq_mask) : '0;

  // ------------------------------------------------------------
  // Retained state
  // ------------------------------------------------------------
  // Only power-on clears these; an ordinary reset leaves time and trim intact.
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      ctrl_keep  <= CTRL_RESET;
      clock_trim <= '0;
    end else begin
      ctrl_keep  <= run_open ? ((next_keep & ~(DATA_W'(1) << B_RUN))
                              | (DATA_W'(wdata[B_RUN]) << B_RUN)) : next_keep;  // [R11]
      clock_trim <= trim_open ? wdata[TRIM_W:0] : clock_trim;           // [R14]
    end
  end

  // Seconds and subsecond counters, also battery held.
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      subsec  <= '0;
      seconds <= '0;
    end else if (count_open) begin
      subsec  <= hit_sub ? wdata[SUB_W-1:0] : subsec;
      seconds <= hit_sechi ? {wdata, seconds[DATA_W-1:0]}
               : (hit_seclo ? {seconds[SEC_W-1:DATA_W], wdata} : seconds);
    end else if (tick_d) begin
      subsec  <= subsec + 1'b1;                                         // [R16]
      seconds <= (subsec == '1) ? seconds + 1'b1 : seconds;             // [R16]
    end
  end

  // ------------------------------------------------------------
  // Non-retained control and busy handshake
  // ------------------------------------------------------------
  // Busy holds for two 32K edges: the first loads the copy, the second proves it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_plain   <= CTRL_RESET;
      write_enable <= 1'b0;
      busy         <= 1'b1;                                             // [R4]
      busy_cnt     <= BUSY_EDGES;
    end else begin
      ctrl_plain   <= ctrl_open ? (wdata & CTRL_PLAIN_MASK) : ctrl_plain;
      write_enable <= wr_ctrl ? wdata[B_WE] : write_enable;             // [R10]
      if (busy_start) begin
        busy     <= 1'b1;
        busy_cnt <= BUSY_EDGES;
      end else if (busy && edge32) begin
        busy_cnt <= busy_cnt - 1'b1;
        busy     <= (busy_cnt != 2'h1);                                 // [R17]
      end
    end
  end

  // Copies seen by the 32K side, refreshed only on its edges.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_copy  <= 1'b0;
      trim_copy <= '0;
    end else if (edge32) begin
      run_copy  <= run_now;                                             // [R1] [R17]
      trim_copy <= clock_trim;
    end
  end

  // ------------------------------------------------------------
  // Ready, interrupts and read data
  // ------------------------------------------------------------
  // Ready drops on the tick and rises with the count update one cycle later.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_d   <= 1'b0;
      ready    <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      irq      <= 1'b0;
      rdata    <= '0;
    end else begin
      tick_d   <= tick;
      ready    <= next_ready;
      irq_stat <= next_stat;                                            // [R8]
      irq_mask <= (wr && hit_mask) ? wdata[IRQ_W-1:0] : irq_mask;
      irq      <= next_irq;
      rdata    <= next_rdata;
    end
  end

endmodule : rtc_ctrl_trim
`default_nettype wire

/* verification/rtc_ctrl_trim_props.sv */
// Assertion checker for the clock control and trim block.
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_trim_props (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       resetn,
  // Register port
  input wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input wire logic                       rd,
  input wire logic [rtc_pkg::DATA_W-1:0] rdata,
  // Pins and interrupt
  input wire logic                       osc_ready,
  input wire logic                       tod_alarm_hit,
  input wire logic                       subsec_alarm_hit,
  input wire logic                       irq
);
  import rtc_pkg::*;
  // ------------------------------------------------------------
  // Byte addresses and shared sequences
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_TRIM = {IDX_TRIM, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] A_SUB  = {IDX_SUBSEC, 2'h0};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_IRQ_STAT, 2'h0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_read(logic [ADDR_W-1:0] a);
    rd && addr == a;
  endsequence
  // A control read in the cycle after reset release must still see the reset busy.
  sequence s_reset_read;
    $rose(resetn) ##1 s_read(A_CTRL);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_read_idle_zero: assert property (!rd |=> rdata == '0)
    else $error("read data not zero after an idle cycle");
  chk_unmapped_zero: assert property (rd && addr[1:0] != 2'h0 |=> rdata == '0)
    else $error("unaligned read returned data");
  chk_ctrl_gap_bits: assert property (s_read(A_CTRL) |=> rdata[7:6] == 2'h0)
    else $error("control gap bits not zero");
  chk_osc_ready_view: assert property ($stable(osc_ready) [*6] ##0 s_read(A_CTRL)
    |=> rdata[B_OSCRDY] == osc_ready) else $error("oscillator ready view wrong");
  chk_trim_width: assert property (s_read(A_TRIM) |=> rdata[15:8] == 8'h00)
    else $error("trim read wider than eight bits");
  chk_subsec_width: assert property (s_read(A_SUB) |=> rdata[15:8] == 8'h00)
    else $error("subsecond read wider than eight bits");
  chk_stat_width: assert property (s_read(A_STAT) |=> rdata[15:3] == 13'h0)
    else $error("status read has stray bits");
  // Clearing on read drops the level on the edge that takes the read; the check looks two edges on, where an alarm in the cycle after the read can still race it.
  chk_irq_read_clear: assert property (s_read(A_STAT) ##0 !tod_alarm_hit
    && !subsec_alarm_hit |-> ##2 !irq) else $error("interrupt stayed after status read");
  chk_busy_on_reset: assert property (s_reset_read |=> rdata[B_BUSY])
    else $error("busy not set after reset");
endmodule : rtc_ctrl_trim_props
bind rtc_ctrl_trim rtc_ctrl_trim_props u_props (.mclk(mclk), .resetn(resetn), .addr(addr),
  .rd(rd), .rdata(rdata), .osc_ready(osc_ready), .tod_alarm_hit(tod_alarm_hit),
  .subsec_alarm_hit(subsec_alarm_hit), .irq(irq));
`default_nettype wire

/* verification/tb_rtc_ctrl_trim.sv */
// Self-checking bench for the clock control and trim block.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_ctrl_trim;
  import rtc_pkg::*;
  // ------------------------------------------------------------
  // Addresses, table and signals
  // ------------------------------------------------------------
  localparam int         EDGES  = 1200; // Past one short trim period plus a full removal.
  localparam logic [7:0] A_TRIM = {IDX_TRIM, 2'h0};
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [7:0] A_SUB  = {IDX_SUBSEC, 2'h0};
  localparam logic [7:0] A_STAT = {IDX_IRQ_STAT, 2'h0};
  localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'h0};
  typedef struct packed { logic [7:0] trim; logic [7:0] sub; } rtc_row_t;
  // Subsecond after EDGES: plain, insert 127 and remove 127, all mid-tick.
  rtc_row_t   rows [3] = '{'{8'h00, 8'h09}, '{8'h7f, 8'h0a}, '{8'hff, 8'h08}};
  logic       mclk, resetn, por_n, wr, rd, osc_clk32, osc_ready;
  logic       tod_alarm_hit, subsec_alarm_hit;
  logic [7:0] addr;
  logic [15:0] wdata, rv;
  wire logic [15:0] rdata;
  wire logic  irq;
  int         err_count, n_compared;

  // Trim period shortened to 1024 edges so a run crosses it within about 16384 cycles.
  rtc_ctrl_trim #(.TRIM_PERIOD_EDGES(1024)) u_dut (.mclk(mclk), .resetn(resetn),
    .por_n(por_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .osc_clk32(osc_clk32), .osc_ready(osc_ready), .tod_alarm_hit(tod_alarm_hit),
    .subsec_alarm_hit(subsec_alarm_hit), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // Data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    check(rv & m, e);
  endtask : rd_chk
  // Oscillator pin is sped up to 16 cycles a period; it idles low between bursts.
  task automatic osc(input int n);
    repeat (n) begin
      osc_clk32 <= 1'b1;
      repeat (8) @(posedge mclk);
      osc_clk32 <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask : osc
  task automatic wait_idle();
    for (int i = 0; i < 16; i++) begin
      rd_chk(A_CTRL, 16'h0000, 16'h0000);
      if (rv[B_BUSY] === 1'b0) return;
      osc(1);
    end
    err_count++;
    $display("unexpected at %0t: busy never cleared", $time);
    test_done();
  endtask : wait_idle
  task automatic do_reset(input logic por);
    @(posedge mclk);
    resetn <= 1'b0;
    por_n <= ~por;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    por_n <= 1'b1;
  endtask : do_reset
  task automatic pulse(input logic t, input logic s, input logic e);
    @(posedge mclk);
    tod_alarm_hit <= t;
    subsec_alarm_hit <= s;
    @(posedge mclk);
    tod_alarm_hit <= 1'b0;
    subsec_alarm_hit <= 1'b0;
    @(posedge mclk);
    #1;
    check({15'h0, irq}, {15'h0, e});
  endtask : pulse
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {err_count, n_compared} = '0;
    {resetn, por_n, wr, rd, osc_clk32, tod_alarm_hit, subsec_alarm_hit} = '0;
    osc_ready = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    // Each row starts from power-on so prescaler and trim period begin at zero.
    foreach (rows[i]) begin
      do_reset(1'b1);
      rd_chk(A_CTRL, 16'h0008, 16'h0008);
      wait_idle();
      wr_reg(A_CTRL, 16'h8000);
      wr_reg(A_TRIM, {8'h00, rows[i].trim});
      rd_chk(A_CTRL, 16'h0008, 16'h0008);
      wait_idle();
      rd_chk(A_TRIM, 16'hffff, {8'h00, rows[i].trim});
      wr_reg(A_CTRL, 16'h8001);
      osc(EDGES);
      rd_chk(A_SUB, 16'hffff, {8'h00, rows[i].sub});
      rd_chk(A_CTRL, 16'h8019, 16'h8011);
    end
    // Stop while keeping ready; a write during busy is dropped except for bit 15.
    wr_reg(A_CTRL, 16'h8010);
    rd_chk(A_CTRL, 16'h0008, 16'h0008);
    wr_reg(A_CTRL, 16'h8012);
    rd_chk(A_CTRL, 16'h8007, 16'h8000);
    wait_idle();
    wr_reg(A_CTRL, 16'h8000);
    rd_chk(A_CTRL, 16'h0010, 16'h0010);
    wr_reg(A_CTRL, 16'h8011);
    wait_idle();
    wr_reg(A_CTRL, 16'h8001);
    rd_chk(A_CTRL, 16'h0010, 16'h0000);
    wr_reg(A_CTRL, 16'h8011);
    rd_chk(A_CTRL, 16'h0010, 16'h0000);
    // Write-enable off: run bit and trim hold their values.
    wr_reg(A_CTRL, 16'h0001);
    wr_reg(A_CTRL, 16'h0000);
    rd_chk(A_CTRL, 16'h8009, 16'h0001);
    wr_reg(A_TRIM, 16'h0012);
    rd_chk(A_TRIM, 16'hffff, 16'h00ff);
    // Alarm events: disabled, enabled, then masked.
    wr_reg(A_MASK, 16'h0007);
    pulse(1'b1, 1'b1, 1'b0);
    rd_chk(A_STAT, 16'hffff, 16'h0000);
    wr_reg(A_CTRL, 16'h0007);
    wait_idle();
    pulse(1'b1, 1'b1, 1'b1);
    rd_chk(A_STAT, 16'hffff, 16'h0006);
    wr_reg(A_MASK, 16'h0005);
    pulse(1'b1, 1'b0, 1'b0);
    rd_chk(A_STAT, 16'hffff, 16'h0002);
    // Ready interrupt from a real tick.
    wr_reg(A_CTRL, 16'h0021);
    wait_idle();
    rd_chk(A_STAT, 16'h0000, 16'h0000);
    wr_reg(A_MASK, 16'h0001);
    osc(140);
    #1;
    check({15'h0, irq}, 16'h0001);
    rd_chk(A_STAT, 16'hffff, 16'h0001);
    rd_chk(A_CTRL, 16'h0010, 16'h0010);
    // System reset only: retained run bit and trim survive.
    do_reset(1'b0);
    rd_chk(A_CTRL, 16'h8029, 16'h0009);
    rd_chk(A_TRIM, 16'hffff, 16'h00ff);
    osc_ready <= 1'b0;
    repeat (6) @(posedge mclk);
    rd_chk(A_CTRL, 16'h2000, 16'h0000);
    rd_chk(8'h65, 16'hffff, 16'h0000);
    rd_chk(8'hfc, 16'hffff, 16'h0000);
    test_done();
  end
endmodule : tb_rtc_ctrl_trim
`default_nettype wire
